/* File: ivc_params.svh */
`ifndef IVC_PARAMS_SVH
`define IVC_PARAMS_SVH
// How it works
// R1 - Vector address is the base pointer plus the slot's fixed byte offset.
// R2 - Thirty-two slots, one per trap number, eight bytes apart, last at F8.
// R3 - Reset, hardware or software, uses offset 0, slot 0, priority 0.
// R4 - Host-port event: offset 50, priority 14, low pair bit 10.
// R5 - OS kernel event: offset D0, priority 26, high pair bit 10.
// R6 - DMA channel 1 event: offset 48, priority 13, low pair bit 9.
// R7 - Serial 0 receive: offset 28, priority 7, low pair bit 5.
// R8 - Serial 0 transmit: offset 88, priority 8, high pair bit 1.
// R9 - A maskable interrupt is taken only when its enable bit is set.
// R10 - A flag bit shows pending, whatever its enable bit holds.
// R11 - Debug enables count only while the core is halted in real-time mode.
// R12 - In real-time halt, service needs both debug enable and normal enable.
// R13 - Writing one to a debug enable bit enables it during halt; zero disables.
// R14 - Debug enables keep their contents through hardware and software reset.
// R15 - Low pair bits 15..9 map DMA5,DMA4,S2TX,S2RX,EXT3,HOST,DMA1; bit 8 reserved.
// R16 - Low pair bits 7..2 map S1TX,S1RX,S0RX,T0,EXT2,EXT0; bits 1,0 reserved.
// R17 - High pair: 15..11 reserved; 10..8 OS,LOG,BUS_ERROR_EVENT; 7..0 EXT5,T1,DMA3,DMA2,EXT4,DMA0,S0TX,EXT1.
// R18 - NMI and request pins are sampled each CPU clock for synchronisation.
// R19 - A request is detected only on samples high, low, low, low.
// R20 - The source holds a pin low three clock periods after being high.
// R21 - The enabled pending interrupt of smallest priority wins; ack clears its flag.
// R22 - NMI and reset are serviced regardless of any enable bit.
`define A_FLAGS_LO   4'h0
`define A_EN_LO      4'h1
`define A_DFLAGS_LO  4'h2
`define A_DEN_LO     4'h3
`define A_FLAGS_HI   4'h4
`define A_EN_HI      4'h5
`define A_DFLAGS_HI  4'h6
`define A_DEN_HI     4'h7
`define A_VB_DATA    4'h8
`define A_VB_HOST    4'h9
`define A_STATUS     4'ha
`define VALID_MASK   32'h07fffefc
`define VB_RESET     16'h0000
`define SLOT_RESET   5'h00
`define SLOT_NMI     5'h01
`define HOST_LO      5'h10
`define HOST_HI      5'h17
`define DET_PATTERN  4'h8
`define PRIO_FIRST   2
`define PRIO_LAST    26
// Slot number for each priority 31..0, five bits each
`define PRIO_TABLE {5'h1f, 5'h1e, 5'h1d, 5'h1c, 5'h1b, 5'h1a, 5'h19, 5'h17, \
  5'h16, 5'h0f, 5'h0e, 5'h15, 5'h14, 5'h0d, 5'h0c, 5'h13, 5'h0b, 5'h0a, \
  5'h09, 5'h12, 5'h08, 5'h07, 5'h06, 5'h11, 5'h05, 5'h04, 5'h03, 5'h10, \
  5'h02, 5'h18, 5'h01, 5'h00}
`endif

/* File: ivc_pkg.sv */
package ivc_pkg;
  typedef struct packed {
    logic       timer0;
    logic       timer1;
    logic [2:0] ser_rx;
    logic [2:0] ser_tx;
    logic [5:0] dma;
    logic       host;
    logic       bus_err;
    logic       data_log;
    logic       os_kernel;
  } periph_events_t;
  typedef enum logic [1:0] {
    K_RESET = 2'b00,
    K_NMI   = 2'b01,
    K_TRAP  = 2'b11,
    K_MASK  = 2'b10
  } src_kind_t;
  typedef struct packed {
    logic        req;
    logic [4:0]  slot;
    logic [4:0]  prio;
    logic [23:0] addr;
  } vec_out_t;
endpackage : ivc_pkg

/* File: dsp_interrupt_vector_controller.sv */
`timescale 1ns/1ns
`include "ivc_params.svh"
module dsp_interrupt_vector_controller #(
  parameter int PINS = 6
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic [3:0]              bus_addr,
  input  wire logic [15:0]             bus_wdata,
  input  wire logic                    bus_wr,
  input  wire logic                    bus_rd,
  output logic [15:0]                  bus_rdata,
  input  wire logic                    nmi_pin_b,
  input  wire logic [PINS-1:0]         external_request_pin_b,
  input  wire ivc_pkg::periph_events_t events,
  input  wire logic                    soft_reset,
  input  wire logic                    trap_req,
  input  wire logic [4:0]              trap_num,
  input  wire logic                    core_rt_halted,
  input  wire logic                    core_ack,
  output ivc_pkg::vec_out_t            vector
);
  localparam logic [159:0] PTAB = `PRIO_TABLE;

  if (PINS != 6) begin : g_check
    $error("Six external request pins are required");
  end

  logic [31:0]        flags;
  logic [31:0]        en;
  logic [31:0]        dbg_en;
  logic [15:0]        vb_data;
  logic [15:0]        vb_host;
  logic               reset_pend;
  logic               nmi_pend;
  logic               trap_pend;
  logic [4:0]         trap_slot;
  ivc_pkg::src_kind_t kind_q;
  logic [PINS:0]      sync1;
  logic [PINS:0]      sync2;
  logic [3:0]         hist [PINS+1];
  logic [PINS:0]      hit;

  // Pin synchronisers and pattern detectors; index PINS is the NMI pin
  wire [PINS:0] pins_b = {nmi_pin_b, external_request_pin_b};
  for (genvar k = 0; k <= PINS; k++) begin : g_pin
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        sync1[k] <= 1'b1;
        sync2[k] <= 1'b1;
        hist[k]  <= 4'h0;
      end else begin
        sync1[k] <= pins_b[k]; // R18
        sync2[k] <= sync1[k];
        hist[k]  <= {hist[k][2:0], sync2[k]};
      end
    end
    // Only a clean high-to-low with three low samples counts
    assign hit[k] = (hist[k] == `DET_PATTERN); // R19
  end

  // Event placement in the flag pairs
  wire [31:0] evt = {5'h00, events.os_kernel, events.data_log, events.bus_err,
                     hit[5], events.timer1, events.dma[3], events.dma[2],
                     hit[4], events.dma[0], events.ser_tx[0], hit[1],
                     events.dma[5], events.dma[4], events.ser_tx[2],
                     events.ser_rx[2], hit[3], events.host, events.dma[1],
                     1'b0, events.ser_tx[1], events.ser_rx[1],
                     events.ser_rx[0], events.timer0, hit[2], hit[0],
                     2'b00}; // R15 R16 R17 R4 R5 R6 R7 R8

  // Bus decode
  wire wr_flo = bus_wr && (bus_addr == `A_FLAGS_LO || bus_addr == `A_DFLAGS_LO);
  wire wr_fhi = bus_wr && (bus_addr == `A_FLAGS_HI || bus_addr == `A_DFLAGS_HI);
  wire wr_elo = bus_wr && bus_addr == `A_EN_LO;
  wire wr_ehi = bus_wr && bus_addr == `A_EN_HI;
  wire wr_dlo = bus_wr && bus_addr == `A_DEN_LO;
  wire wr_dhi = bus_wr && bus_addr == `A_DEN_HI;
  wire wr_vbd = bus_wr && bus_addr == `A_VB_DATA;
  wire wr_vbh = bus_wr && bus_addr == `A_VB_HOST;

  // Acknowledge applies to what is being presented
  wire ack       = core_ack && vector.req;
  wire ack_mask  = ack && kind_q == ivc_pkg::K_MASK;
  wire [31:0] ack_clr = ack_mask ? (32'h1 << vector.slot) : 32'h0;
  wire [31:0] w1c = {wr_fhi ? bus_wdata : 16'h0000, wr_flo ? bus_wdata : 16'h0000};
  wire [31:0] clr = w1c | ack_clr | {32{soft_reset}};
  // New events win over any clear in the same cycle
  wire [31:0] next_flags = ((flags & ~clr) | evt) & `VALID_MASK; // R10 R21

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      flags <= 32'h0;
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b || soft_reset) begin
      en <= 32'h0;
    end else begin
      if (wr_elo) en[15:0] <= bus_wdata & 16'hfefc;
      if (wr_ehi) en[31:16] <= bus_wdata & 16'h07ff;
    end
  end

  // Left out of reset on purpose: software sets these before real-time debug
  always_ff @(posedge clk_sys) begin
    if (wr_dlo) dbg_en[15:0] <= bus_wdata & 16'hfefc; // R13 R14
    if (wr_dhi) dbg_en[31:16] <= bus_wdata & 16'h07ff; // R13 R14
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vb_data <= `VB_RESET;
      vb_host <= `VB_RESET;
    end else begin
      if (wr_vbd) vb_data <= bus_wdata;
      if (wr_vbh) vb_host <= bus_wdata;
    end
  end

  // Non-maskable sources
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reset_pend <= 1'b1;
      nmi_pend   <= 1'b0;
      trap_pend  <= 1'b0;
      trap_slot  <= 5'h00;
    end else begin
      if (soft_reset) reset_pend <= 1'b1; // R3
      else if (ack && kind_q == ivc_pkg::K_RESET) reset_pend <= 1'b0;
      if (hit[PINS]) nmi_pend <= 1'b1;
      else if (ack && kind_q == ivc_pkg::K_NMI) nmi_pend <= 1'b0;
      if (trap_req && (!trap_pend || (ack && kind_q == ivc_pkg::K_TRAP))) begin
        trap_pend <= 1'b1;
        trap_slot <= trap_num;
      end else if (ack && kind_q == ivc_pkg::K_TRAP) begin
        trap_pend <= 1'b0;
      end
    end
  end

  // Halted in real-time mode, both enable sets must agree
  wire [31:0] gate = core_rt_halted ? (en & dbg_en) : en; // R11 R12
  wire [31:0] elig = flags & gate & `VALID_MASK; // R9

  logic       found;
  logic [4:0] m_slot;
  logic [4:0] m_prio;
  logic [4:0] t_prio;
  always_comb begin
    found  = 1'b0;
    m_slot = 5'h00;
    m_prio = 5'h00;
    t_prio = 5'h00;
    for (int p = `PRIO_FIRST; p <= `PRIO_LAST; p++) begin
      if (!found && elig[PTAB[p*5 +: 5]]) begin
        found  = 1'b1; // R21
        m_slot = PTAB[p*5 +: 5];
        m_prio = 5'(p);
      end
    end
    for (int p = 0; p < 32; p++) begin
      if (PTAB[p*5 +: 5] == trap_slot) t_prio = 5'(p);
    end
  end

  // Reset and NMI ahead of everything, enables not consulted
  ivc_pkg::src_kind_t next_kind;
  logic [4:0]         next_slot;
  logic [4:0]         next_prio;
  always_comb begin
    if (reset_pend) begin
      next_kind = ivc_pkg::K_RESET; // R3 R22
      next_slot = `SLOT_RESET;
      next_prio = 5'h00;
    end else if (nmi_pend) begin
      next_kind = ivc_pkg::K_NMI; // R22
      next_slot = `SLOT_NMI;
      next_prio = 5'h01;
    end else if (trap_pend) begin
      next_kind = ivc_pkg::K_TRAP;
      next_slot = trap_slot;
      next_prio = t_prio;
    end else begin
      next_kind = ivc_pkg::K_MASK;
      next_slot = m_slot;
      next_prio = m_prio;
    end
  end

  wire        next_req  = (reset_pend || nmi_pend || trap_pend || found) && !ack;
  wire        use_host  = next_slot >= `HOST_LO && next_slot <= `HOST_HI;
  wire [15:0] base      = use_host ? vb_host : vb_data;
  // Eight bytes per slot puts slot 31 at F8
  wire [23:0] next_addr = {base, 8'h00} + {16'h0000, next_slot, 3'b000}; // R1 R2

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      vector <= '0;
      kind_q <= ivc_pkg::K_RESET;
    end else begin
      vector.req  <= next_req;
      vector.slot <= next_slot;
      vector.prio <= next_prio;
      vector.addr <= next_addr;
      kind_q      <= next_kind;
    end
  end

  // Read path; reserved bits read zero
  wire [15:0] status = {reset_pend, nmi_pend, trap_pend, vector.req, 7'h00,
                        vector.slot};
  logic [15:0] rd_mux;
  always_comb begin
    case (bus_addr)
      `A_FLAGS_LO, `A_DFLAGS_LO: rd_mux = flags[15:0];
      `A_FLAGS_HI, `A_DFLAGS_HI: rd_mux = flags[31:16];
      `A_EN_LO:    rd_mux = en[15:0];
      `A_EN_HI:    rd_mux = en[31:16];
      `A_DEN_LO:   rd_mux = dbg_en[15:0];
      `A_DEN_HI:   rd_mux = dbg_en[31:16];
      `A_VB_DATA:  rd_mux = vb_data;
      `A_VB_HOST:  rd_mux = vb_host;
      `A_STATUS:   rd_mux = status;
      default:     rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bus_rdata <= 16'h0000;
    end else if (bus_rd) begin
      bus_rdata <= rd_mux;
    end else begin
      bus_rdata <= 16'h0000;
    end
  end

  a_reset_slot: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
    reset_pend && !ack |=> vector.req && vector.slot == 5'h00 && vector.prio == 5'h00)
    else $error("Reset not presented at slot 0");

  a_nmi_unmasked: assert property (@(posedge clk_sys) disable iff (!rst_b) // R22
    nmi_pend && !reset_pend && !ack |=> vector.req && vector.slot == 5'h01)
    else $error("NMI not presented");

  a_pin_detect: assert property (@(posedge clk_sys) disable iff (!rst_b) // R19
    $past(sync2[0]) && !sync2[0] ##1 !sync2[0] ##1 !sync2[0] |=> ##1 flags[2])
    else $error("External request 0 missed");

  a_no_false: assert property (@(posedge clk_sys) disable iff (!rst_b) // R19
    !flags[2] && !hit[0] |=> !flags[2])
    else $error("External request 0 flag without pattern");

  // Gates are checked on the winner being loaded, so the slot and enables line up
  a_mask_gate: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
    next_req && next_kind == ivc_pkg::K_MASK |-> en[next_slot])
    else $error("Masked interrupt presented");

  a_halt_gate: assert property (@(posedge clk_sys) disable iff (!rst_b) // R12
    next_req && next_kind == ivc_pkg::K_MASK && core_rt_halted
    |-> dbg_en[next_slot])
    else $error("Non time-critical interrupt served in halt");

  a_ack_clear: assert property (@(posedge clk_sys) disable iff (!rst_b) // R21
    ack_mask && !evt[vector.slot] |=> !flags[$past(vector.slot)])
    else $error("Acknowledged flag not cleared");

  // Vector is registered, so it reflects the pointer of the cycle before
  a_host_vec: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
    vector.req && vector.slot == 5'h0a |-> vector.prio == 5'd14
    && vector.addr == {$past(vb_data), 8'h50})
    else $error("Host vector wrong");

  a_os_vec: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
    vector.req && vector.slot == 5'h1a |-> vector.prio == 5'd26
    && vector.addr == {$past(vb_data), 8'hd0})
    else $error("OS kernel vector wrong");

  a_dma1_vec: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    vector.req && vector.slot == 5'h09 |-> vector.prio == 5'd13
    && vector.addr == {$past(vb_data), 8'h48})
    else $error("DMA channel 1 vector wrong");

  a_rx0_vec: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    vector.req && vector.slot == 5'h05 |-> vector.prio == 5'd7
    && vector.addr == {$past(vb_data), 8'h28})
    else $error("Serial 0 receive vector wrong");

  a_tx0_vec: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    vector.req && vector.slot == 5'h11 |-> vector.prio == 5'd8
    && vector.addr == {$past(vb_host), 8'h88})
    else $error("Serial 0 transmit vector wrong");

  a_last_slot: assert property (@(posedge clk_sys) disable iff (!rst_b) // R2
    vector.req && vector.slot == 5'h1f |-> vector.prio == 5'd31
    && vector.addr == {$past(vb_data), 8'hf8})
    else $error("Last trap vector wrong");

  a_nmi_vec: assert property (@(posedge clk_sys) disable iff (!rst_b) // R22
    vector.req && vector.slot == 5'h01 |-> vector.prio == 5'd1
    && vector.addr == {$past(vb_data), 8'h08})
    else $error("NMI vector wrong");

  a_external_request_zero_vec: assert property (@(posedge clk_sys) disable iff (!rst_b) // R1
    vector.req && vector.slot == 5'h02 |-> vector.prio == 5'd3
    && vector.addr == {$past(vb_data), 8'h10})
    else $error("External request 0 vector wrong");

  a_reset_addr: assert property (@(posedge clk_sys) disable iff (!rst_b) // R3
    vector.req && kind_q == ivc_pkg::K_RESET
    |-> vector.addr == {$past(vb_data), 8'h00})
    else $error("Reset vector address wrong");

  // Flags follow events whatever the enables hold
  a_host_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // R10
    events.host |=> flags[10])
    else $error("Host flag not set");

  a_os_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // R5
    events.os_kernel |=> flags[26])
    else $error("OS kernel flag not set");

  a_dma1_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // R6
    events.dma[1] |=> flags[9])
    else $error("DMA channel 1 flag not set");

  a_rx0_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // R7
    events.ser_rx[0] |=> flags[5])
    else $error("Serial 0 receive flag not set");

  a_tx0_flag: assert property (@(posedge clk_sys) disable iff (!rst_b) // R8
    events.ser_tx[0] |=> flags[17])
    else $error("Serial 0 transmit flag not set");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b) // R17
    flags[31:27] == 5'h00 && flags[8] == 1'b0 && flags[1:0] == 2'b00
    && en[31:27] == 5'h00 && en[8] == 1'b0 && en[1:0] == 2'b00)
    else $error("Reserved flag or enable bit set");

  a_en_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // R9
    wr_elo && !soft_reset |=> en[15:0] == ($past(bus_wdata) & 16'hfefc))
    else $error("Enable low write lost");

  a_dbg_write: assert property (@(posedge clk_sys) disable iff (!rst_b) // R13
    wr_dlo |=> dbg_en[15:0] == ($past(bus_wdata) & 16'hfefc))
    else $error("Debug enable low write lost");

  a_run_ignores: assert property (@(posedge clk_sys) disable iff (!rst_b) // R11
    !core_rt_halted && !reset_pend && !nmi_pend && !trap_pend && !ack
    && (flags & en) != 32'h0 |=> vector.req && kind_q == ivc_pkg::K_MASK)
    else $error("Running core blocked by debug enables");

  a_prio_order: assert property (@(posedge clk_sys) disable iff (!rst_b) // R21
    next_kind == ivc_pkg::K_MASK && elig[9] && elig[10] |-> next_slot != 5'h0a)
    else $error("Host served ahead of DMA channel 1");

  a_ack_gap: assert property (@(posedge clk_sys) disable iff (!rst_b) // R21
    ack |=> !vector.req)
    else $error("Request not dropped after acknowledge");

  a_nmi_detect: assert property (@(posedge clk_sys) disable iff (!rst_b) // R19
    hit[PINS] |=> nmi_pend)
    else $error("NMI pattern missed");

  // Unknown before the first write makes this vacuous until software sets bit 10
  a_dbg_keep: assert property (@(posedge clk_sys) // R14
    (!rst_b || soft_reset) && !bus_wr && dbg_en[10] |=> dbg_en[10])
    else $error("Debug enables lost at reset");
endmodule : dsp_interrupt_vector_controller

/* File: core_seq_model.sv */
`timescale 1ns/1ns
module core_seq_model (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire ivc_pkg::vec_out_t vector,
  input  wire logic              accept,
  input  wire logic [3:0]        delay,
  output logic                   core_ack,
  output ivc_pkg::vec_out_t      taken,
  output int                     n_taken
);
  logic [3:0] wait_cnt;
  // Count survives reset so the bench can wait across one
  initial n_taken = 0;
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      core_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (core_ack) begin
      core_ack <= 1'b0;
      wait_cnt <= 4'h0;
      taken    <= vector;
      n_taken  <= n_taken + 1;
    end else if (accept && vector.req) begin
      if (wait_cnt >= delay) core_ack <= 1'b1;
      else wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule : core_seq_model

/* File: testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic                    clk_sys;
  logic                    rst_b;
  logic [3:0]              bus_addr;
  logic [15:0]             bus_wdata;
  logic                    bus_wr;
  logic                    bus_rd;
  logic [15:0]             bus_rdata;
  logic                    nmi_pin_b;
  logic [5:0]              pin_b;
  ivc_pkg::periph_events_t ev;
  ivc_pkg::periph_events_t e;
  logic                    soft_reset;
  logic                    trap_req;
  logic [4:0]              trap_num;
  logic                    halted;
  logic                    core_ack;
  logic                    accept;
  logic [3:0]              delay;
  ivc_pkg::vec_out_t       vector;
  ivc_pkg::vec_out_t       taken;
  int                      n_taken;
  logic [15:0]             vb_data = 16'h0000;
  logic [15:0]             vb_host = 16'h0000;
  int                      n_fail = 0;
  int                      num_checks = 0;

  dsp_interrupt_vector_controller uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .nmi_pin_b(nmi_pin_b),
    .external_request_pin_b(pin_b), .events(ev), .soft_reset(soft_reset),
    .trap_req(trap_req), .trap_num(trap_num), .core_rt_halted(halted),
    .core_ack(core_ack), .vector(vector));
  core_seq_model partner (
    .clk_sys(clk_sys), .rst_b(rst_b), .vector(vector), .accept(accept), .delay(delay),
    .core_ack(core_ack), .taken(taken), .n_taken(n_taken));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk_sys);
    bus_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk_sys);
    bus_rd <= 1'b0;
    @(negedge clk_sys);
    chk("register", 35'(exp), 35'(bus_rdata));
    @(posedge clk_sys);
  endtask : rd

  task automatic fire(input ivc_pkg::periph_events_t x);
    ev <= x;
    @(posedge clk_sys);
    ev <= '0;
  endtask : fire

  // Index 6 stands for the nonmaskable pin
  task automatic pin_low(input int k, input int n);
    if (k == 6) nmi_pin_b <= 1'b0;
    else pin_b[k] <= 1'b0;
    repeat (n) @(posedge clk_sys);
    nmi_pin_b <= 1'b1;
    pin_b     <= 6'h3f;
  endtask : pin_low

  function automatic ivc_pkg::vec_out_t exp_vec(input logic [4:0] s, input logic [4:0] p);
    logic [15:0] ptr;
    ptr = (s >= 5'h10 && s <= 5'h17) ? vb_host : vb_data;
    exp_vec = '{req: 1'b1, slot: s, prio: p, addr: {ptr, 8'h00} + {16'h0, s, 3'b000}};
  endfunction : exp_vec

  task automatic take(input logic [4:0] s, input logic [4:0] p);
    int n0;
    n0 = n_taken;
    repeat (40) if (n_taken == n0) @(posedge clk_sys);
    chk("serviced", 35'h1, 35'(n_taken - n0));
    chk("vector", exp_vec(s, p), taken);
  endtask : take

  task automatic no_take();
    int n0;
    n0 = n_taken;
    repeat (20) @(posedge clk_sys);
    chk("services", 35'h0, 35'(n_taken - n0));
  endtask : no_take

  task automatic wrap_up();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    wrap_up();
  end

  initial begin
    rst_b = 1'b0;
    bus_addr = 4'h0;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    nmi_pin_b = 1'b1;
    pin_b = 6'h3f;
    ev = '0;
    soft_reset = 1'b0;
    trap_req = 1'b0;
    trap_num = 5'h00;
    halted = 1'b0;
    accept = 1'b1;
    delay = 4'h0;
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    take(5'h00, 5'h00);
    rd(4'h1, 16'h0000);
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'hfefc);
    wr(4'h5, 16'hffff);
    rd(4'h5, 16'h07ff);
    rd(4'hb, 16'h0000);
    wr(4'h3, 16'h0400);
    wr(4'h7, 16'h0000);
    rd(4'h3, 16'h0400);
    vb_data = 16'h0012;
    vb_host = 16'h0034;
    wr(4'h8, vb_data);
    wr(4'h9, vb_host);
    accept <= 1'b0;
    e = '0;
    e.host = 1'b1;
    e.dma[1] = 1'b1;
    e.ser_rx[0] = 1'b1;
    e.ser_tx[0] = 1'b1;
    e.os_kernel = 1'b1;
    fire(e);
    rd(4'h0, 16'h0620);
    rd(4'h6, 16'h0402);
    rd(4'ha, 16'h1005);
    delay <= 4'h3;
    accept <= 1'b1;
    take(5'h05, 5'h07);
    take(5'h11, 5'h08);
    take(5'h09, 5'h0d);
    take(5'h0a, 5'h0e);
    take(5'h1a, 5'h1a);
    // Host is debug-enabled, channel one is not
    halted <= 1'b1;
    e = '0;
    e.host = 1'b1;
    e.dma[1] = 1'b1;
    fire(e);
    take(5'h0a, 5'h0e);
    no_take();
    halted <= 1'b0;
    take(5'h09, 5'h0d);
    pin_low(0, 2);
    no_take();
    pin_low(0, 3);
    take(5'h02, 5'h03);
    pin_low(1, 3);
    take(5'h10, 5'h04);
    for (int t = 0; t < 2; t++) begin
      trap_req <= 1'b1;
      trap_num <= t ? 5'h08 : 5'h1f;
      @(posedge clk_sys);
      trap_req <= 1'b0;
      take(trap_num, t ? 5'h0b : 5'h1f);
    end
    vb_data = 16'h0000;
    vb_host = 16'h0000;
    wr(4'h8, vb_data);
    wr(4'h9, vb_host);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
    take(5'h00, 5'h00);
    rd(4'h1, 16'h0000);
    rd(4'h3, 16'h0400);
    e = '0;
    e.timer0 = 1'b1;
    fire(e);
    no_take();
    rd(4'h0, 16'h0010);
    wr(4'h2, 16'h0010);
    rd(4'h0, 16'h0000);
    pin_low(6, 3);
    take(5'h01, 5'h01);
    rst_b <= 1'b0;
    @(posedge clk_sys);
    rst_b <= 1'b1;
    take(5'h00, 5'h00);
    rd(4'h3, 16'h0400);
    wrap_up();
  end
endmodule : testbench
